// *** inc/ttc_map.svh ***
`ifndef TTC_MAP_SVH
`define TTC_MAP_SVH

// Register byte offsets
`define TTC_OFF_MODE 8'h00
`define TTC_OFF_CTRL 8'h04
`define TTC_OFF_U0_LOW 8'h08
`define TTC_OFF_U0_HIGH 8'h0c
`define TTC_OFF_U1_LOW 8'h10
`define TTC_OFF_U1_HIGH 8'h14
`define TTC_OFF_U2_CTRL 8'h18
`define TTC_OFF_U2_MODE 8'h1c
`define TTC_OFF_U2_LOW 8'h20
`define TTC_OFF_U2_HIGH 8'h24
`define TTC_OFF_CAP_LOW 8'h28
`define TTC_OFF_CAP_HIGH 8'h2c
`define TTC_OFF_IRQ_EN 8'h30
`define TTC_OFF_CLK_CFG 8'h34

// Timer mode register fields
`define TTC_GATE1 7
`define TTC_FSEL1 6
`define TTC_MODE1_LSB 4
`define TTC_GATE0 3
`define TTC_FSEL0 2
`define TTC_MODE0_LSB 0

// Timer control register fields
`define TTC_OVF1 7
`define TTC_RUN1 6
`define TTC_OVF0 5
`define TTC_RUN0 4

// Third unit control, mode and interrupt enable fields, and clock config field
`define TTC_OVF2 7
`define TTC_EXT2 6
`define TTC_EXT_EN2 3
`define TTC_RUN2 2
`define TTC_FSEL2 1
`define TTC_CAPTURE 0
`define TTC_DOWN_EN 0
`define TTC_IRQ_EN2 5
`define TTC_TWELVE 0

// Reset values
`define TTC_RST_BYTE 8'h00
`define TTC_RST_BIT 1'b0

// Machine-cycle prescaler terminal counts (osc/6, osc/12)
`define TTC_PRESC_LAST_FAST 4'h5
`define TTC_PRESC_LAST_SLOW 4'hb

// Bus responses
`define TTC_RESP_OKAY 2'b00
`define TTC_RESP_SLVERR 2'b10

`endif

// *** inc/ttc_pkg.sv ***
`default_nettype none
package ttc_pkg;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT = 2'b11
  } unit_mode_type;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_type;

  typedef struct packed {
    logic unit0_count_pin;
    logic unit1_count_pin;
    logic third_unit_count_pin;
    logic unit0_interrupt_pin_n;
    logic unit1_interrupt_pin_n;
    logic third_unit_trigger_pin;
  } pin_type;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic ovf;
  } step_type;

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] timer_mode_register;
    logic unit0_run_control;
    logic unit1_run_control;
    logic unit0_overflow_flag;
    logic unit1_overflow_flag;
    logic third_unit_overflow_flag;
    logic third_unit_external_flag;
    logic third_unit_external_enable;
    logic third_unit_run_control;
    logic third_unit_function_select;
    logic third_unit_capture_mode;
    logic down_count_enable;
    logic third_unit_irq_enable;
    logic twelve_clock_mode;
    logic [7:0] unit0_low_byte;
    logic [7:0] unit0_high_byte;
    logic [7:0] unit1_low_byte;
    logic [7:0] unit1_high_byte;
    logic [7:0] third_unit_low_byte;
    logic [7:0] third_unit_high_byte;
    logic [7:0] capture_reload_low;
    logic [7:0] capture_reload_high;
    logic [3:0] presc;
    logic unit1_ovf_pulse;
    logic third_unit_request;
    pin_type sync1;
    pin_type sync2;
    pin_type prev;
  } state_type;

endpackage
`default_nettype wire

// *** rtl/triple_timer_counter_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ttc_map.svh"

module triple_timer_counter_unit
  import ttc_pkg::*;
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Register bus
  input wire axi_req_type axi_req,
  output axi_rsp_type axi_rsp,
  // External pins
  input wire pin_type pins,
  // Status toward the system
  output logic unit0_overflow_flag,
  output logic unit1_overflow_flag,
  output logic unit1_overflow_pulse,
  output logic third_unit_request
);

  ////////////////////////////////////////////////////////////////////////////
  // One count event on a unit's two bytes
  function automatic step_type unit_step(
    input logic [1:0] mode,
    input logic [7:0] lo,
    input logic [7:0] hi,
    input logic pulse
  );
    step_type s;
    logic [12:0] c13;
    logic [15:0] c16;
    s.low = lo;
    s.high = hi;
    s.ovf = 1'b0;
    c13 = {hi, lo[4:0]} + 13'h0001;
    c16 = {hi, lo} + 16'h0001;
    if (pulse) begin
      case (mode)
        MODE_13BIT: begin
          s.high = c13[12:5];
          s.low = {lo[7:5], c13[4:0]};
          s.ovf = (c13 == 13'h0000);
        end
        MODE_16BIT: begin
          s.high = c16[15:8];
          s.low = c16[7:0];
          s.ovf = (c16 == 16'h0000);
        end
        MODE_RELOAD8: begin
          // High byte is only the reload value here
          if (lo == 8'hff) begin
            s.low = hi;
            s.ovf = 1'b1;
          end else begin
            s.low = lo + 8'h01;
          end
        end
        default: begin
          s.low = lo + 8'h01;
          s.ovf = (lo == 8'hff);
        end
      endcase
    end
    return s;
  endfunction

  // Aligned offsets inside the map answer OKAY
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `TTC_OFF_CLK_CFG);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  state_type cur;
  state_type next_cur;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic [7:0] waddr;
  logic [7:0] wbyte;
  logic wr_en;
  logic mc_tick;
  logic [3:0] presc_last;
  pin_type fall;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic en0;
  logic en1;
  logic en2;
  logic pulse0;
  logic pulse1;
  logic pulse0_high;
  logic pulse2;
  logic trig2;
  logic split;
  step_type s0;
  step_type s1;
  step_type s0_high;
  logic [15:0] cnt2;
  logic [15:0] cap2;
  logic ovf2;
  logic ext2_set;
  logic ext2_tgl;
  logic ovf2_base;
  logic ext2_base;
  logic ext2_may_request;
  logic [7:0] rbyte;

  assign axi_rsp.awready = clk_en && !cur.aw_got && !cur.bvalid;
  assign axi_rsp.wready = clk_en && !cur.w_got && !cur.bvalid;
  assign axi_rsp.arready = clk_en && !cur.rvalid;
  assign axi_rsp.bvalid = cur.bvalid;
  assign axi_rsp.bresp = cur.bresp;
  assign axi_rsp.rvalid = cur.rvalid;
  assign axi_rsp.rdata = {24'h000000, cur.rdata};
  assign axi_rsp.rresp = cur.rresp;
  assign unit0_overflow_flag = cur.unit0_overflow_flag;
  assign unit1_overflow_flag = cur.unit1_overflow_flag;
  assign unit1_overflow_pulse = cur.unit1_ovf_pulse;
  assign third_unit_request = cur.third_unit_request;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cur = cur;

    // Pin synchronisers and fall detection
    next_cur.sync1 = pins;
    next_cur.sync2 = cur.sync1;
    next_cur.prev = cur.sync2;
    // Prev starts low, so no false fall after reset
    fall = cur.prev & ~cur.sync2;

    // Machine-cycle prescaler
    presc_last = cur.twelve_clock_mode ? `TTC_PRESC_LAST_SLOW : `TTC_PRESC_LAST_FAST;
    mc_tick = (cur.presc >= presc_last);
    next_cur.presc = mc_tick ? 4'h0 : cur.presc + 4'h1;

    // Units 0 and 1
    mode0 = cur.timer_mode_register[`TTC_MODE0_LSB +: 2];
    mode1 = cur.timer_mode_register[`TTC_MODE1_LSB +: 2];
    // Split: unit 0 high byte takes unit 1 run bit and flag
    split = (mode0 == MODE_SPLIT);
    en0 = cur.unit0_run_control && (!cur.timer_mode_register[`TTC_GATE0]
      || cur.sync2.unit0_interrupt_pin_n);
    // Unit 1 ignores its run bit while unit 0 is split
    en1 = (split || cur.unit1_run_control) && (!cur.timer_mode_register[`TTC_GATE1]
      || cur.sync2.unit1_interrupt_pin_n);
    pulse0 = en0 && (cur.timer_mode_register[`TTC_FSEL0] ?
      fall.unit0_count_pin : mc_tick);
    pulse1 = en1 && (mode1 != MODE_SPLIT) && (cur.timer_mode_register[`TTC_FSEL1] ?
      fall.unit1_count_pin : mc_tick);
    pulse0_high = split && cur.unit1_run_control && mc_tick;
    s0 = unit_step(mode0, cur.unit0_low_byte, cur.unit0_high_byte, pulse0);
    s1 = unit_step(mode1, cur.unit1_low_byte, cur.unit1_high_byte, pulse1);
    s0_high.low = cur.unit0_high_byte;
    s0_high.high = 8'h00;
    s0_high.ovf = 1'b0;
    if (pulse0_high) begin
      s0_high.low = cur.unit0_high_byte + 8'h01;
      s0_high.ovf = (cur.unit0_high_byte == 8'hff);
    end
    next_cur.unit0_low_byte = s0.low;
    next_cur.unit0_high_byte = split ? s0_high.low : s0.high;
    next_cur.unit1_low_byte = s1.low;
    next_cur.unit1_high_byte = s1.high;
    next_cur.unit1_ovf_pulse = s1.ovf;

    // Third unit
    cnt2 = {cur.third_unit_high_byte, cur.third_unit_low_byte};
    cap2 = {cur.capture_reload_high, cur.capture_reload_low};
    en2 = cur.third_unit_run_control;
    pulse2 = en2 && (cur.third_unit_function_select ?
      fall.third_unit_count_pin : mc_tick);
    trig2 = cur.third_unit_external_enable && fall.third_unit_trigger_pin;
    ovf2 = 1'b0;
    ext2_set = 1'b0;
    ext2_tgl = 1'b0;
    // Capture takes the count from before this cycle's event
    if (cur.third_unit_capture_mode) begin
      if (pulse2) begin
        cnt2 = cnt2 + 16'h0001;
        ovf2 = (cnt2 == 16'h0000);
      end
      if (trig2) begin
        cap2 = {cur.third_unit_high_byte, cur.third_unit_low_byte};
        ext2_set = 1'b1;
      end
    end else if (!cur.down_count_enable) begin
      if (pulse2) begin
        if (cnt2 == 16'hffff) begin
          cnt2 = cap2;
          ovf2 = 1'b1;
        end else begin
          cnt2 = cnt2 + 16'h0001;
        end
      end
      if (trig2) begin
        cnt2 = cap2;
        ext2_set = 1'b1;
      end
    end else if (pulse2) begin
      // Direction from the synchronised trigger pin
      if (cur.sync2.third_unit_trigger_pin) begin
        if (cnt2 == 16'hffff) begin
          cnt2 = cap2;
          ovf2 = 1'b1;
        end else begin
          cnt2 = cnt2 + 16'h0001;
        end
      end else begin
        if (cnt2 == cap2) begin
          cnt2 = 16'hffff;
          ovf2 = 1'b1;
        end else begin
          cnt2 = cnt2 - 16'h0001;
        end
      end
      ext2_tgl = ovf2;
    end
    next_cur.third_unit_high_byte = cnt2[15:8];
    next_cur.third_unit_low_byte = cnt2[7:0];
    next_cur.capture_reload_high = cap2[15:8];
    next_cur.capture_reload_low = cap2[7:0];

    // Write channel
    aw_hs = axi_req.awvalid && axi_rsp.awready;
    w_hs = axi_req.wvalid && axi_rsp.wready;
    ar_hs = axi_req.arvalid && axi_rsp.arready;
    if (aw_hs) begin
      next_cur.aw_got = 1'b1;
      next_cur.aw_addr = axi_req.awaddr;
    end
    if (w_hs) begin
      next_cur.w_got = 1'b1;
      next_cur.w_data = axi_req.wdata[7:0];
      next_cur.w_lane0 = axi_req.wstrb[0];
    end
    // Address and data may come in either order
    do_write = next_cur.aw_got && next_cur.w_got;
    waddr = next_cur.aw_addr;
    wbyte = next_cur.w_data;
    wr_en = do_write && next_cur.w_lane0 && mapped(waddr);
    if (do_write) begin
      next_cur.aw_got = 1'b0;
      next_cur.w_got = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = mapped(waddr) ? `TTC_RESP_OKAY : `TTC_RESP_SLVERR;
    end else if (cur.bvalid && axi_req.bready) begin
      next_cur.bvalid = 1'b0;
    end

    // Flag bases: a software write replaces the old value
    next_cur.unit0_overflow_flag = cur.unit0_overflow_flag;
    next_cur.unit1_overflow_flag = cur.unit1_overflow_flag;
    ovf2_base = cur.third_unit_overflow_flag;
    ext2_base = cur.third_unit_external_flag;

    // Software writes to a count byte win over a count
    if (wr_en) begin
      case (waddr)
        `TTC_OFF_MODE: next_cur.timer_mode_register = wbyte;
        `TTC_OFF_CTRL: begin
          next_cur.unit0_overflow_flag = wbyte[`TTC_OVF0];
          next_cur.unit1_overflow_flag = wbyte[`TTC_OVF1];
          next_cur.unit0_run_control = wbyte[`TTC_RUN0];
          next_cur.unit1_run_control = wbyte[`TTC_RUN1];
        end
        `TTC_OFF_U0_LOW: next_cur.unit0_low_byte = wbyte;
        `TTC_OFF_U0_HIGH: next_cur.unit0_high_byte = wbyte;
        `TTC_OFF_U1_LOW: next_cur.unit1_low_byte = wbyte;
        `TTC_OFF_U1_HIGH: next_cur.unit1_high_byte = wbyte;
        `TTC_OFF_U2_CTRL: begin
          ovf2_base = wbyte[`TTC_OVF2];
          ext2_base = wbyte[`TTC_EXT2];
          next_cur.third_unit_external_enable = wbyte[`TTC_EXT_EN2];
          next_cur.third_unit_run_control = wbyte[`TTC_RUN2];
          next_cur.third_unit_function_select = wbyte[`TTC_FSEL2];
          next_cur.third_unit_capture_mode = wbyte[`TTC_CAPTURE];
        end
        `TTC_OFF_U2_MODE: next_cur.down_count_enable = wbyte[`TTC_DOWN_EN];
        `TTC_OFF_U2_LOW: next_cur.third_unit_low_byte = wbyte;
        `TTC_OFF_U2_HIGH: next_cur.third_unit_high_byte = wbyte;
        `TTC_OFF_CAP_LOW: next_cur.capture_reload_low = wbyte;
        `TTC_OFF_CAP_HIGH: next_cur.capture_reload_high = wbyte;
        `TTC_OFF_IRQ_EN: next_cur.third_unit_irq_enable = wbyte[`TTC_IRQ_EN2];
        `TTC_OFF_CLK_CFG: next_cur.twelve_clock_mode = wbyte[`TTC_TWELVE];
        default: ;
      endcase
    end

    // Hardware set wins over a software clear
    next_cur.unit0_overflow_flag = next_cur.unit0_overflow_flag | s0.ovf;
    next_cur.unit1_overflow_flag = next_cur.unit1_overflow_flag
      | (split ? s0_high.ovf : s1.ovf);
    next_cur.third_unit_overflow_flag = ovf2_base | ovf2;
    next_cur.third_unit_external_flag = (ext2_base ^ ext2_tgl) | ext2_set;
    // External flag stays silent while counting up and down
    ext2_may_request = next_cur.third_unit_capture_mode || !next_cur.down_count_enable;
    next_cur.third_unit_request = next_cur.third_unit_irq_enable
      && (next_cur.third_unit_overflow_flag
      || (next_cur.third_unit_external_flag && ext2_may_request));

    // Read channel
    // Unmapped or unaligned offsets read as zero
    case (axi_req.araddr)
      `TTC_OFF_MODE: rbyte = cur.timer_mode_register;
      `TTC_OFF_CTRL: rbyte = {cur.unit1_overflow_flag, cur.unit1_run_control,
        cur.unit0_overflow_flag, cur.unit0_run_control, 4'h0};
      `TTC_OFF_U0_LOW: rbyte = cur.unit0_low_byte;
      `TTC_OFF_U0_HIGH: rbyte = cur.unit0_high_byte;
      `TTC_OFF_U1_LOW: rbyte = cur.unit1_low_byte;
      `TTC_OFF_U1_HIGH: rbyte = cur.unit1_high_byte;
      `TTC_OFF_U2_CTRL: rbyte = {cur.third_unit_overflow_flag, cur.third_unit_external_flag,
        2'b00, cur.third_unit_external_enable, cur.third_unit_run_control,
        cur.third_unit_function_select, cur.third_unit_capture_mode};
      `TTC_OFF_U2_MODE: rbyte = {7'h00, cur.down_count_enable};
      `TTC_OFF_U2_LOW: rbyte = cur.third_unit_low_byte;
      `TTC_OFF_U2_HIGH: rbyte = cur.third_unit_high_byte;
      `TTC_OFF_CAP_LOW: rbyte = cur.capture_reload_low;
      `TTC_OFF_CAP_HIGH: rbyte = cur.capture_reload_high;
      `TTC_OFF_IRQ_EN: rbyte = {2'b00, cur.third_unit_irq_enable, 5'h00};
      `TTC_OFF_CLK_CFG: rbyte = {7'h00, cur.twelve_clock_mode};
      default: rbyte = 8'h00;
    endcase
    if (ar_hs) begin
      next_cur.rvalid = 1'b1;
      next_cur.rdata = rbyte;
      next_cur.rresp = mapped(axi_req.araddr) ? `TTC_RESP_OKAY : `TTC_RESP_SLVERR;
    end else if (cur.rvalid && axi_req.rready) begin
      next_cur.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    // Reset acts whatever the clock enable
    if (!aresetn) begin
      cur <= '0;
      cur.timer_mode_register <= `TTC_RST_BYTE;
      cur.down_count_enable <= `TTC_RST_BIT;
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

endmodule
`default_nettype wire

// *** sim/ttc_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ttc_map.svh"
module ttc_monitor
  import ttc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Bus and pins
  input wire axi_req_type axi_req,
  input wire axi_rsp_type axi_rsp,
  input wire pin_type pins,
  // Status
  input wire logic unit0_overflow_flag,
  input wire logic unit1_overflow_flag,
  input wire logic unit1_overflow_pulse,
  input wire logic third_unit_request
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  bvalid_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write answer dropped early");
  rvalid_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read answer dropped early");
  write_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
    && axi_rsp.wready |=> axi_rsp.bvalid) else $error("write answer late");
  read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  rdata_upper_a: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  stall_ready_a: assert property (!clk_en |-> !axi_rsp.awready && !axi_rsp.wready
    && !axi_rsp.arready) else $error("ready while stalled");
  busy_refuse_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while answer pending");
  baud_pulse_a: assert property (unit1_overflow_pulse && clk_en |=> !unit1_overflow_pulse)
    else $error("baud pulse longer than one cycle");
  flag_freeze_a: assert property (!clk_en |=> $stable(unit0_overflow_flag)
    && $stable(unit1_overflow_flag) && $stable(third_unit_request)) else $error("flag moved");
  reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> !axi_rsp.bvalid
    && !axi_rsp.rvalid && !unit0_overflow_flag && !unit1_overflow_flag
    && !third_unit_request) else $error("output not cleared by reset");
  cover property (unit1_overflow_pulse);
  cover property (third_unit_request);
  cover property (!pins.third_unit_trigger_pin);
  cover property (axi_rsp.rvalid && axi_rsp.rresp == `TTC_RESP_SLVERR);
endmodule

bind triple_timer_counter_unit ttc_monitor u_mon (.aclk, .aresetn, .clk_en, .axi_req,
  .axi_rsp, .pins, .unit0_overflow_flag, .unit1_overflow_flag, .unit1_overflow_pulse,
  .third_unit_request);
`default_nettype wire

// *** sim/pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_model
  import ttc_pkg::*;
#(
  parameter int HOLD = 3
)
(
  // Clock
  input wire logic aclk,
  // Pins toward the unit
  output var pin_type pins
);
  // Idle: count pins high, gates open, trigger high
  initial pins = 6'h3f;
  // Each level held long enough for the pin synchroniser
  task automatic level(input int i, input logic v);
    @(posedge aclk);
    pins[i] <= v;
    repeat (HOLD) @(posedge aclk);
  endtask
  task automatic pulse(input int i);
    level(i, 1'b0);
    level(i, 1'b1);
  endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ttc_map.svh"
module tb_top;
  import ttc_pkg::*;
  localparam int TRG = 0;
  localparam int G1 = 1;
  localparam int G0 = 2;
  localparam int C2 = 3;
  localparam int C1 = 4;
  localparam int C0 = 5;
  logic aclk;
  logic aresetn;
  logic clk_en;
  axi_req_type req;
  axi_rsp_type rsp;
  pin_type pins;
  logic u0f;
  logic u1f;
  logic u1p;
  logic t2req;
  logic seen;
  logic [7:0] q;
  logic [1:0] r;
  int per;
  int n_errors = 0;
  int num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  triple_timer_counter_unit u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .axi_req(req), .axi_rsp(rsp), .pins(pins), .unit0_overflow_flag(u0f),
    .unit1_overflow_flag(u1f), .unit1_overflow_pulse(u1p), .third_unit_request(t2req));
  pin_model u_pins (.aclk(aclk), .pins(pins));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
    logic aw;
    logic w;
    logic ar;
    logic done;
    @(posedge aclk);
    req.awvalid <= is_wr;
    req.wvalid <= is_wr;
    req.bready <= is_wr;
    req.arvalid <= !is_wr;
    req.rready <= !is_wr;
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hf;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      aw = req.awvalid && rsp.awready;
      w = req.wvalid && rsp.wready;
      ar = req.arvalid && rsp.arready;
      done = is_wr ? (req.bready && rsp.bvalid) : (req.rready && rsp.rvalid);
      q = rsp.rdata[7:0];
      r = is_wr ? rsp.bresp : rsp.rresp;
      @(posedge aclk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (ar) req.arvalid <= 1'b0;
      if (done) begin
        req.bready <= 1'b0;
        req.rready <= 1'b0;
        return;
      end
    end
    n_errors++;
    $display("[FAIL] bus answer expected 1 seen 0");
    end_sim();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // Cycles from one baud pulse to the next
  task automatic gap(output int n);
    int k;
    k = 0;
    @(negedge aclk);
    while (!u1p && k < 40) begin
      @(negedge aclk);
      k++;
    end
    @(negedge aclk);
    n = 1;
    while (!u1p && n < 40) begin
      @(negedge aclk);
      n++;
    end
  endtask
  // Looks for any baud pulse within a bounded span
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(negedge aclk);
      seen = seen | u1p;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    clk_en = 1'b0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    clk_en <= 1'b1;
    for (int a = 0; a <= 8'h34; a += 4) rd(8'(a), 8'h00);
    xfer(1'b0, 8'h38, 8'h00);
    chk("unmapped resp", {6'h00, `TTC_RESP_SLVERR}, {6'h00, r});
    // Unit 0, counter, gated, 16-bit
    wr(`TTC_OFF_U0_LOW, 8'hfe);
    wr(`TTC_OFF_U0_HIGH, 8'hff);
    wr(`TTC_OFF_MODE, 8'h0d);
    u_pins.level(G0, 1'b0);
    wr(`TTC_OFF_CTRL, 8'h10);
    rd(`TTC_OFF_U0_LOW, 8'hfe);
    u_pins.pulse(C0);
    rd(`TTC_OFF_U0_LOW, 8'hfe);
    u_pins.level(G0, 1'b1);
    u_pins.pulse(C0);
    u_pins.pulse(C0);
    rd(`TTC_OFF_U0_HIGH, 8'h00);
    rd(`TTC_OFF_CTRL, 8'h30);
    chk("unit0 flag", 8'h01, {7'h00, u0f});
    // Unit 1, counter, gated, 13-bit
    wr(`TTC_OFF_U1_LOW, 8'h1f);
    wr(`TTC_OFF_U1_HIGH, 8'hff);
    wr(`TTC_OFF_MODE, 8'hc0);
    u_pins.level(G1, 1'b0);
    wr(`TTC_OFF_CTRL, 8'h40);
    u_pins.pulse(C1);
    rd(`TTC_OFF_U1_LOW, 8'h1f);
    u_pins.level(G1, 1'b1);
    u_pins.pulse(C1);
    rd(`TTC_OFF_U1_HIGH, 8'h00);
    rd(`TTC_OFF_U1_LOW, 8'h00);
    chk("unit1 flag", 8'h01, {7'h00, u1f});
    // Unit 0, 8-bit reload
    wr(`TTC_OFF_CTRL, 8'h00);
    wr(`TTC_OFF_U0_LOW, 8'hff);
    wr(`TTC_OFF_U0_HIGH, 8'ha5);
    wr(`TTC_OFF_MODE, 8'h06);
    wr(`TTC_OFF_CTRL, 8'h10);
    u_pins.pulse(C0);
    rd(`TTC_OFF_U0_LOW, 8'ha5);
    rd(`TTC_OFF_U0_HIGH, 8'ha5);
    rd(`TTC_OFF_CTRL, 8'h30);
    u_pins.pulse(C0);
    rd(`TTC_OFF_U0_LOW, 8'ha6);
    // Split: unit 0 two counters, unit 1 held
    wr(`TTC_OFF_CTRL, 8'h00);
    wr(`TTC_OFF_MODE, 8'h77);
    wr(`TTC_OFF_U0_HIGH, 8'hff);
    wr(`TTC_OFF_U0_LOW, 8'h00);
    wr(`TTC_OFF_U1_LOW, 8'h10);
    wr(`TTC_OFF_CTRL, 8'h50);
    u_pins.pulse(C1);
    u_pins.pulse(C0);
    rd(`TTC_OFF_U1_LOW, 8'h10);
    rd(`TTC_OFF_U0_LOW, 8'h01);
    rd(`TTC_OFF_CTRL, 8'hd0);
    // Unit 1 as baud source beside split unit 0
    wr(`TTC_OFF_CTRL, 8'h10);
    wr(`TTC_OFF_U1_LOW, 8'hff);
    wr(`TTC_OFF_U1_HIGH, 8'hff);
    wr(`TTC_OFF_MODE, 8'h27);
    watch(40);
    chk("baud pulse", 8'h01, {7'h00, seen});
    chk("unit1 flag", 8'h00, {7'h00, u1f});
    gap(per);
    chk("baud period", 8'h06, 8'(per));
    wr(`TTC_OFF_CLK_CFG, 8'h01);
    gap(per);
    chk("slow period", 8'h0c, 8'(per));
    wr(`TTC_OFF_CLK_CFG, 8'h00);
    wr(`TTC_OFF_MODE, 8'h37);
    repeat (2) @(posedge aclk);
    watch(30);
    chk("baud stopped", 8'h00, {7'h00, seen});
    // Third unit capture
    wr(`TTC_OFF_U2_LOW, 8'h34);
    wr(`TTC_OFF_U2_HIGH, 8'h12);
    wr(`TTC_OFF_IRQ_EN, 8'h20);
    wr(`TTC_OFF_U2_CTRL, 8'h0f);
    repeat (3) u_pins.pulse(C2);
    u_pins.pulse(TRG);
    rd(`TTC_OFF_CAP_LOW, 8'h37);
    rd(`TTC_OFF_CAP_HIGH, 8'h12);
    chk("third request", 8'h01, {7'h00, t2req});
    u_pins.pulse(C2);
    rd(`TTC_OFF_U2_LOW, 8'h38);
    rd(`TTC_OFF_U2_CTRL, 8'h4f);
    // Third unit up reload
    wr(`TTC_OFF_U2_CTRL, 8'h06);
    wr(`TTC_OFF_CAP_LOW, 8'h21);
    wr(`TTC_OFF_CAP_HIGH, 8'h43);
    wr(`TTC_OFF_U2_LOW, 8'hff);
    wr(`TTC_OFF_U2_HIGH, 8'hff);
    u_pins.pulse(C2);
    rd(`TTC_OFF_U2_LOW, 8'h21);
    rd(`TTC_OFF_U2_HIGH, 8'h43);
    rd(`TTC_OFF_U2_CTRL, 8'h86);
    wr(`TTC_OFF_U2_CTRL, 8'h0e);
    wr(`TTC_OFF_U2_LOW, 8'h00);
    u_pins.pulse(TRG);
    rd(`TTC_OFF_U2_LOW, 8'h21);
    rd(`TTC_OFF_U2_CTRL, 8'h4e);
    chk("third request", 8'h01, {7'h00, t2req});
    // Third unit up/down
    wr(`TTC_OFF_U2_CTRL, 8'h06);
    wr(`TTC_OFF_U2_MODE, 8'h01);
    u_pins.level(TRG, 1'b0);
    wr(`TTC_OFF_U2_LOW, 8'h22);
    repeat (2) u_pins.pulse(C2);
    rd(`TTC_OFF_U2_HIGH, 8'hff);
    rd(`TTC_OFF_U2_CTRL, 8'hc6);
    wr(`TTC_OFF_U2_CTRL, 8'h46);
    rd(`TTC_OFF_U2_MODE, 8'h01);
    chk("third request", 8'h00, {7'h00, t2req});
    u_pins.level(TRG, 1'b1);
    wr(`TTC_OFF_U2_LOW, 8'hff);
    wr(`TTC_OFF_U2_HIGH, 8'hff);
    u_pins.pulse(C2);
    rd(`TTC_OFF_U2_LOW, 8'h21);
    rd(`TTC_OFF_U2_HIGH, 8'h43);
    rd(`TTC_OFF_U2_CTRL, 8'h86);
    end_sim();
  end
endmodule
`default_nettype wire
